// >>> tidc_pkg.sv
// constants and types for the transceiver select configuration loader
// Operation
// RQ1: sample select straps at power-up and reset
// RQ2: first boot or changed code loads set
// RQ3: same code, not 30: compare rate, clock
// RQ4: any mismatch reinitializes all stored parameters
// RQ5: custom code 30 makes port lines inputs
// RQ6: board ties straps high or low
// RQ7: transformer pair codes 1 and 3
// RQ8: code 4 free topology, 78kbps
// RQ9: rs-485 codes 5, 10, 12, 11
// RQ10: power line codes 15, 16, 17
// RQ11: direct connect codes 27, 28, 29
// RQ12: host loads custom parameters for code 30
// RQ13: keep code and set nonvolatile; store image holds code, rate, clock only, so custom slots are lost
package tidc_pkg;
  // ************************************************************
  // codes and encodings
  // ************************************************************
  localparam int CODE_W = 5;
  localparam int PORT_W = 5;
  localparam logic [4:0] CODE_CUSTOM = 5'h1E;
  // bit rate encodings
  localparam logic [3:0] RATE_NONE = 4'h0;
  localparam logic [3:0] RATE_78K = 4'h1;
  localparam logic [3:0] RATE_1M25 = 4'h2;
  localparam logic [3:0] RATE_39K = 4'h3;
  localparam logic [3:0] RATE_62K = 4'h4;
  localparam logic [3:0] RATE_2613 = 4'h5;
  localparam logic [3:0] RATE_5K = 4'h6;
  // input clock encodings
  localparam logic [1:0] ICLK_NONE = 2'h0;
  localparam logic [1:0] ICLK_10M = 2'h1;
  // media encodings
  localparam logic [2:0] MEDIA_NONE = 3'h0;
  localparam logic [2:0] MEDIA_XFMR = 3'h1;
  localparam logic [2:0] MEDIA_FREE = 3'h2;
  localparam logic [2:0] MEDIA_RS485 = 3'h3;
  localparam logic [2:0] MEDIA_PL_A = 3'h4;
  localparam logic [2:0] MEDIA_PL_C = 3'h5;
  localparam logic [2:0] MEDIA_DIRECT = 3'h6;
  localparam logic [2:0] MEDIA_CUSTOM = 3'h7;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [4:0] CODE_RST = 5'h00;
  localparam logic [4:0] SLOTS_RST = 5'h00;

  typedef enum logic [4:0] {
    TIDC_IDLE = 5'b00001,
    TIDC_SAMPLE = 5'b00010,
    TIDC_DECIDE = 5'b00100,
    TIDC_LOAD = 5'b01000,
    TIDC_RUN = 5'b10000
  } tidc_state_e;
endpackage

// >>> tidc_table.sv
// lookup of predefined parameters for a select code
`timescale 1ns/100ps
module tidc_table
  import tidc_pkg::*;
(
  // select code
  input wire logic [4:0] code,
  // parameter set
  output logic valid,
  output logic [3:0] rate,
  output logic [1:0] iclk,
  output logic [4:0] slots,
  output logic [2:0] media,
  output logic cenelec
);
  always_comb begin
    valid = 1'b1;
    rate = RATE_NONE;
    iclk = ICLK_10M;
    slots = 5'h00;
    media = MEDIA_NONE;
    cenelec = 1'b0;
    unique case (code)
      5'h01: begin rate = RATE_78K; slots = 5'h04; media = MEDIA_XFMR; end // see RQ7
      5'h03: begin rate = RATE_1M25; slots = 5'h10; media = MEDIA_XFMR; end // see RQ7
      5'h04: begin rate = RATE_78K; slots = 5'h04; media = MEDIA_FREE; end // see RQ8
      5'h05: begin rate = RATE_39K; slots = 5'h04; media = MEDIA_RS485; end // see RQ9
      5'h0A: begin rate = RATE_62K; slots = 5'h04; media = MEDIA_RS485; end // see RQ9
      5'h0B: begin rate = RATE_1M25; slots = 5'h10; media = MEDIA_RS485; end // see RQ9
      5'h0C: begin rate = RATE_78K; slots = 5'h04; media = MEDIA_RS485; end // see RQ9
      5'h0F: begin rate = RATE_2613; slots = 5'h08; media = MEDIA_PL_A; end // see RQ10
      5'h10: begin rate = RATE_5K; slots = 5'h06; media = MEDIA_PL_C; cenelec = 1'b1; end // see RQ10
      5'h11: begin rate = RATE_5K; slots = 5'h08; media = MEDIA_PL_C; end // see RQ10
      5'h1B: begin rate = RATE_78K; media = MEDIA_DIRECT; end // see RQ11
      5'h1C: begin rate = RATE_62K; media = MEDIA_DIRECT; end // see RQ11
      5'h1D: begin rate = RATE_1M25; media = MEDIA_DIRECT; end // see RQ11
      CODE_CUSTOM: begin iclk = ICLK_NONE; media = MEDIA_CUSTOM; end
      default: begin valid = 1'b0; iclk = ICLK_NONE; end
    endcase
  end
endmodule

// >>> tidc_top.sv
// transceiver select configuration loader: strap sampling and parameter store
`timescale 1ns/100ps
module tidc_top
  import tidc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // board straps, asynchronous
  input wire logic [4:0] transceiver_select_straps,
  // power-up marker: high for the first boot after power is applied
  input wire logic power_up,
  // nonvolatile store image, as read back at boot
  input wire logic nv_valid,
  input wire logic [4:0] nv_code,
  input wire logic [3:0] nv_rate,
  input wire logic [1:0] nv_iclk,
  // host processor link write of custom parameters
  input wire logic host_processor_link_wr,
  input wire logic [3:0] host_rate,
  input wire logic [1:0] host_iclk,
  input wire logic [4:0] host_slots,
  // communication port line enables
  output logic [4:0] comm_port_lines_oe,
  // active parameters
  output logic [4:0] active_code,
  output logic [3:0] active_rate,
  output logic [1:0] active_iclk,
  output logic [4:0] active_slots,
  output logic [2:0] active_media,
  output logic active_cenelec,
  // nonvolatile write request
  output logic nv_wr,
  // status
  output logic config_done,
  output logic reinit_done,
  output logic custom_mode,
  output logic code_invalid
);
  // ************************************************************
  // strap synchroniser
  // ************************************************************
  // no reset here: the stages only follow the pins, and every reset outlasts them
  logic [4:0] s1_r, s2_r, s3_r;
  logic [4:0] s1_nxt, s2_nxt, s3_nxt;
  always_comb begin
    s1_nxt = transceiver_select_straps;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end
  always_ff @(posedge ref_clk) begin
    s1_r <= s1_nxt;
    s2_r <= s2_nxt;
    s3_r <= s3_nxt;
  end
  // straps are static; only a settled value (stages two and three agree) is taken
  wire straps_stable = (s2_r == s3_r);

  // ************************************************************
  // table lookup
  // ************************************************************
  logic [4:0] code_r, code_nxt;
  logic t_valid, t_cen;
  logic [3:0] t_rate;
  logic [1:0] t_iclk;
  logic [4:0] t_slots;
  logic [2:0] t_media;
  tidc_table u_table (
    .code(code_r),
    .valid(t_valid),
    .rate(t_rate),
    .iclk(t_iclk),
    .slots(t_slots),
    .media(t_media),
    .cenelec(t_cen)
  );

  // ************************************************************
  // control state machine
  // ************************************************************
  tidc_state_e st_r, st_nxt;
  logic [4:0] oe_r, oe_nxt;
  logic [3:0] rate_r, rate_nxt;
  logic [1:0] iclk_r, iclk_nxt;
  logic [4:0] slots_r, slots_nxt;
  logic [2:0] media_r, media_nxt;
  logic cen_r, cen_nxt;
  logic nvwr_r, nvwr_nxt;
  logic done_r, done_nxt;
  logic reinit_r, reinit_nxt;
  logic cust_r, cust_nxt;
  logic inv_r, inv_nxt;
  logic pwr_r, pwr_nxt;
  logic first_r, first_nxt;

  always_comb begin
    st_nxt = st_r;
    code_nxt = code_r;
    oe_nxt = oe_r;
    rate_nxt = rate_r;
    iclk_nxt = iclk_r;
    slots_nxt = slots_r;
    media_nxt = media_r;
    cen_nxt = cen_r;
    nvwr_nxt = 1'b0;
    done_nxt = done_r;
    reinit_nxt = reinit_r;
    cust_nxt = cust_r;
    inv_nxt = inv_r;
    pwr_nxt = pwr_r;
    first_nxt = first_r;
    unique case (st_r)
      TIDC_IDLE: begin
        // nothing is driven until the code is known
        oe_nxt = 5'h00;
        pwr_nxt = power_up;
        // store image must be settled here; it is read again only in decide
        first_nxt = ~nv_valid;
        st_nxt = TIDC_SAMPLE;
      end
      TIDC_SAMPLE: begin
        if (straps_stable) begin
          code_nxt = s3_r; // see RQ1
          st_nxt = TIDC_DECIDE;
        end
      end
      TIDC_DECIDE: begin
        cust_nxt = (code_r == CODE_CUSTOM);
        inv_nxt = ~t_valid;
        if (first_r || (code_r != nv_code)) begin
          st_nxt = TIDC_LOAD; // see RQ2
        end else if ((code_r != CODE_CUSTOM) && ((t_rate != nv_rate) || (t_iclk != nv_iclk))) begin // see RQ3
          reinit_nxt = 1'b1;
          st_nxt = TIDC_LOAD; // see RQ4
        end else begin
          // stored set still matches the table, or the code is custom and not compared; keep it
          // slots are not in the store image, so they follow the table:
          // a host-written custom slot count reads back as zero after a reboot
          rate_nxt = nv_rate;
          iclk_nxt = nv_iclk;
          slots_nxt = t_slots;
          media_nxt = t_media;
          cen_nxt = t_cen;
          st_nxt = TIDC_RUN;
        end
      end
      TIDC_LOAD: begin
        rate_nxt = t_rate; // see RQ2
        iclk_nxt = t_iclk;
        slots_nxt = t_slots;
        media_nxt = t_media;
        cen_nxt = t_cen;
        nvwr_nxt = 1'b1; // see RQ13
        st_nxt = TIDC_RUN;
      end
      TIDC_RUN: begin
        done_nxt = 1'b1;
        // custom code leaves every port line an input; the host owns the set
        oe_nxt = cust_r ? 5'h00 : {PORT_W{t_valid}}; // see RQ5
        // writes outside custom mode are dropped with no sign on any port
        if (cust_r && host_processor_link_wr) begin // see RQ12
          rate_nxt = host_rate;
          iclk_nxt = host_iclk;
          slots_nxt = host_slots;
          nvwr_nxt = 1'b1; // see RQ13
        end
      end
      default: st_nxt = TIDC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= TIDC_IDLE;
      code_r <= CODE_RST;
      oe_r <= 5'h00;
      rate_r <= RATE_NONE;
      iclk_r <= ICLK_NONE;
      slots_r <= SLOTS_RST;
      media_r <= MEDIA_NONE;
      cen_r <= 1'b0;
      nvwr_r <= 1'b0;
      done_r <= 1'b0;
      reinit_r <= 1'b0;
      cust_r <= 1'b0;
      inv_r <= 1'b0;
      pwr_r <= 1'b0;
      first_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      code_r <= code_nxt;
      oe_r <= oe_nxt;
      rate_r <= rate_nxt;
      iclk_r <= iclk_nxt;
      slots_r <= slots_nxt;
      media_r <= media_nxt;
      cen_r <= cen_nxt;
      nvwr_r <= nvwr_nxt;
      done_r <= done_nxt;
      reinit_r <= reinit_nxt;
      cust_r <= cust_nxt;
      inv_r <= inv_nxt;
      pwr_r <= pwr_nxt;
      first_r <= first_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign comm_port_lines_oe = oe_r;
  assign active_code = code_r;
  assign active_rate = rate_r;
  assign active_iclk = iclk_r;
  assign active_slots = slots_r;
  assign active_media = media_r;
  assign active_cenelec = cen_r;
  assign nv_wr = nvwr_r;
  assign config_done = done_r;
  assign reinit_done = reinit_r;
  assign custom_mode = cust_r;
  assign code_invalid = inv_r;
endmodule

// >>> tidc_props.sv
// assertion checker on the loader ports
`timescale 1ns/100ps
module tidc_props
  import tidc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // inputs
  input wire logic nv_valid,
  input wire logic [4:0] nv_code,
  input wire logic [3:0] nv_rate,
  input wire logic [1:0] nv_iclk,
  input wire logic host_processor_link_wr,
  input wire logic [3:0] host_rate,
  // outputs
  input wire logic [4:0] comm_port_lines_oe,
  input wire logic [4:0] active_code,
  input wire logic [3:0] active_rate,
  input wire logic [1:0] active_iclk,
  input wire logic nv_wr,
  input wire logic config_done,
  input wire logic reinit_done,
  input wire logic custom_mode,
  input wire logic code_invalid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_custom_off; custom_mode |-> comm_port_lines_oe == 5'h00; endproperty
  a_custom_off: assert property (p_custom_off) else $error("port lines driven in custom mode");
  property p_custom_flag; $rose(config_done) |-> custom_mode == (active_code == CODE_CUSTOM); endproperty
  a_custom_flag: assert property (p_custom_flag) else $error("custom flag wrong");
  property p_idle_off; !config_done |-> comm_port_lines_oe == 5'h00; endproperty
  a_idle_off: assert property (p_idle_off) else $error("port lines driven before done");
  property p_code_hold; config_done |=> $stable(active_code); endproperty
  a_code_hold: assert property (p_code_hold) else $error("code changed after sampling");
  property p_store_code; $rose(config_done) |-> nv_valid && nv_code == active_code; endproperty
  a_store_code: assert property (p_store_code) else $error("store misses code");
  property p_match_keep;
    $rose(config_done) && !reinit_done && !custom_mode && !code_invalid
      |-> active_rate == nv_rate && active_iclk == nv_iclk;
  endproperty
  a_match_keep: assert property (p_match_keep) else $error("active set differs from store");
  property p_reinit; $rose(config_done) && !custom_mode && nv_rate != active_rate |-> reinit_done; endproperty
  a_reinit: assert property (p_reinit) else $error("mismatch without reinit");
  property p_nv_pulse; nv_wr && !config_done |=> !nv_wr; endproperty
  a_nv_pulse: assert property (p_nv_pulse) else $error("load write too long");
  property p_host_take;
    config_done && custom_mode && host_processor_link_wr |=> nv_wr && active_rate == $past(host_rate);
  endproperty
  a_host_take: assert property (p_host_take) else $error("host write lost");
  property p_host_drop; config_done && !custom_mode && host_processor_link_wr |=> !nv_wr && $stable(active_rate); endproperty
  a_host_drop: assert property (p_host_drop) else $error("host write taken");
endmodule
bind tidc_top tidc_props i_tidc_props (.ref_clk, .rst, .nv_valid, .nv_code, .nv_rate, .nv_iclk,
  .host_processor_link_wr, .host_rate, .comm_port_lines_oe, .active_code, .active_rate, .active_iclk,
  .nv_wr, .config_done, .reinit_done, .custom_mode, .code_invalid);

// >>> tidc_board.sv
// board straps and nonvolatile store model
`timescale 1ns/100ps
module tidc_board (
  // control
  input wire logic ref_clk,
  input wire logic [4:0] set_code,
  input wire logic blank,
  input wire logic corrupt,
  // device side
  input wire logic nv_wr,
  input wire logic [4:0] active_code,
  input wire logic [3:0] active_rate,
  input wire logic [1:0] active_iclk,
  output logic [4:0] transceiver_select_straps,
  output logic nv_valid,
  output logic [4:0] nv_code,
  output logic [3:0] nv_rate,
  output logic [1:0] nv_iclk
);
  logic [3:0] rate_r;
  // straps are tied, never floating
  assign transceiver_select_straps = set_code;
  // corrupt stands for a store that no longer matches the table
  assign nv_rate = corrupt ? ~rate_r : rate_r;
  initial begin
    nv_valid = 1'b0;
    nv_code = 5'h00;
    rate_r = 4'h0;
    nv_iclk = 2'h0;
  end
  always @(posedge ref_clk) begin
    if (nv_wr) begin
      nv_valid <= 1'b1;
      nv_code <= active_code;
      rate_r <= active_rate;
      nv_iclk <= active_iclk;
    end else if (blank) begin
      nv_valid <= 1'b0;
    end
  end
endmodule

// >>> testbench.sv
// self-checking testbench for the loader
`timescale 1ns/100ps
module testbench
  import tidc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic power_up = 1'b1;
  logic blank = 1'b0;
  logic corrupt = 1'b0;
  logic host_processor_link_wr = 1'b0;
  logic [4:0] set_code = 5'h01;
  logic [3:0] host_rate = 4'h0;
  logic [1:0] host_iclk = 2'h0;
  logic [4:0] host_slots = 5'h00;
  logic [4:0] transceiver_select_straps, nv_code, comm_port_lines_oe, active_code, active_slots;
  logic nv_valid, nv_wr, config_done, reinit_done, custom_mode, code_invalid, active_cenelec;
  logic [3:0] nv_rate, active_rate;
  logic [1:0] nv_iclk, active_iclk;
  logic [2:0] active_media;
  int n_fail = 0;
  int samples_checked = 0;
  int nw = 0;
  int cyc = 0;
  logic [4:0] tc[13] = '{5'h01, 5'h03, 5'h04, 5'h05, 5'h0A, 5'h0B, 5'h0C, 5'h0F, 5'h10, 5'h11, 5'h1B, 5'h1C, 5'h1D};
  logic [3:0] tr[13] = '{4'h1, 4'h2, 4'h1, 4'h3, 4'h4, 4'h2, 4'h1, 4'h5, 4'h6, 4'h6, 4'h1, 4'h4, 4'h2};
  logic [4:0] ts[13] = '{5'h04, 5'h10, 5'h04, 5'h04, 5'h04, 5'h10, 5'h04, 5'h08, 5'h06, 5'h08, 5'h00, 5'h00, 5'h00};
  logic [2:0] tm[13] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3, 3'h4, 3'h5, 3'h5, 3'h6, 3'h6, 3'h6};
  always #5 ref_clk = ~ref_clk;
  tidc_top i_tidc_top (.ref_clk, .rst, .transceiver_select_straps, .power_up, .nv_valid, .nv_code, .nv_rate,
    .nv_iclk, .host_processor_link_wr, .host_rate, .host_iclk, .host_slots, .comm_port_lines_oe, .active_code,
    .active_rate, .active_iclk, .active_slots, .active_media, .active_cenelec, .nv_wr, .config_done,
    .reinit_done, .custom_mode, .code_invalid);
  tidc_board i_tidc_board (.ref_clk, .set_code, .blank, .corrupt, .nv_wr, .active_code, .active_rate,
    .active_iclk, .transceiver_select_straps, .nv_valid, .nv_code, .nv_rate, .nv_iclk);
  always @(negedge ref_clk) if (nv_wr === 1'b1) nw++;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // straps settle during the whole reset, well over the sync depth
  task automatic boot(input logic [4:0] c, input logic b);
    int n;
    @(posedge ref_clk);
    rst <= 1'b1;
    set_code <= c;
    blank <= b;
    power_up <= b;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    blank <= 1'b0;
    nw = 0;
    n = 0;
    while (config_done !== 1'b1 && n < 30) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(8'(n < 30), 8'h01);
  endtask
  task automatic host_wr(input logic [3:0] r);
    @(posedge ref_clk);
    host_processor_link_wr <= 1'b1;
    host_rate <= r;
    host_iclk <= ICLK_10M;
    host_slots <= 5'h07;
    @(posedge ref_clk);
    host_processor_link_wr <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
  initial begin
    for (int i = 0; i < 13; i++) begin
      boot(tc[i], i == 0);
      chk(8'(nw), 8'h01);
      chk(8'(active_rate), 8'(tr[i]));
      chk(8'(active_slots), 8'(ts[i]));
      chk(8'(active_media), 8'(tm[i]));
      chk(8'(active_iclk), 8'(ICLK_10M));
      chk(8'(active_cenelec), 8'(i == 8));
      chk(8'(active_code), 8'(tc[i]));
      chk(8'(comm_port_lines_oe), 8'h1F);
    end
    $display("test table done");
    boot(5'h1D, 1'b0);
    chk(8'(nw), 8'h00);
    chk(8'(reinit_done), 8'h00);
    host_wr(RATE_5K);
    chk(8'(active_rate), 8'(RATE_1M25));
    chk(8'(nw), 8'h00);
    $display("test same code done");
    boot(5'h1D, 1'b1);
    chk(8'(nw), 8'h01);
    chk(8'(reinit_done), 8'h00);
    $display("test first boot done");
    @(posedge ref_clk);
    corrupt <= 1'b1;
    boot(5'h1D, 1'b0);
    chk(8'(reinit_done), 8'h01);
    chk(8'(active_rate), 8'(RATE_1M25));
    chk(8'(active_slots), 8'h00);
    @(posedge ref_clk);
    corrupt <= 1'b0;
    $display("test reinit done");
    boot(CODE_CUSTOM, 1'b0);
    chk(8'(custom_mode), 8'h01);
    chk(8'(comm_port_lines_oe), 8'h00);
    host_wr(RATE_39K);
    chk(8'(active_rate), 8'(RATE_39K));
    chk(8'(active_slots), 8'h07);
    chk(8'(active_iclk), 8'(ICLK_10M));
    chk(8'(nw), 8'h02);
    $display("test custom done");
    boot(CODE_CUSTOM, 1'b0);
    chk(8'(nw), 8'h00);
    chk(8'(reinit_done), 8'h00);
    chk(8'(active_rate), 8'(RATE_39K));
    $display("test custom keep done");
    boot(5'h02, 1'b0);
    chk(8'(code_invalid), 8'h01);
    chk(8'(comm_port_lines_oe), 8'h00);
    $display("test invalid done");
    print_verdict();
  end
endmodule
